// [design/sram_pkg.sv]
/*
 * Constants and types for the pipelined synchronous SRAM core.
 * Assumes one clock, clk_sys, shared with the memory controller that drives it.
 */
//------------------------------------------------------------------------------
// Overview of operation
// R01: organised as 128K x 36 by default, or 256K x 18 by parameters.
// R02: address and control sampled on one edge; data moves two cycles later.
// R03: reads and writes may alternate on consecutive cycles with no idle cycle.
// R04: cycle_hold_n high ignores synchronous inputs and freezes every register except the burst_order_select synchroniser.
// R05: advance_or_load low while deselected starts nothing; pipeline still completes.
// R06: data lines released two cycles after a deselect or a write start.
// R07: output_enable_n disables data outputs asynchronously at any moment.
// R08: three chip selects; device selected only when all three are asserted.
// R09: each byte lane has its own active-low write select.
// R10: one loaded address yields up to four consecutive data cycles.
// R11: static burst_order_select picks linear or interleaved burst order.
// R12: advance_or_load low loads a new address; high advances the burst counter.
// R13: external address ignored while advance_or_load is high.
// R14: advance_or_load low while deselected terminates any running burst.
// R15: the active-high chip select acts like the low ones, polarity inverted.
// R16: controller drives valid byte writes on load and every burst-write cycle.
// R17: burst steps low two address bits: linear modulo four, interleaved by xor.
//------------------------------------------------------------------------------
package sram_pkg;

	// 128K x 36 default organisation
	localparam int unsigned ADDR_W_DEF = 17;
	localparam int unsigned DATA_W_DEF = 36;
	localparam int unsigned LANES_DEF  = 4;

	// burst counter
	localparam int unsigned BEAT_W     = 2;
	localparam logic [1:0]  BEAT_ZERO  = 2'h0;
	localparam logic [1:0]  BEAT_STEP  = 2'h1;
	localparam logic [1:0]  BEAT_LAST  = 2'h3;

	typedef enum logic [1:0] {
		BURST_IDLE = 2'b01,
		BURST_RUN  = 2'b10
	} burst_state_e;

endpackage

// [design/array_if.sv]
/*
 * Carrier between the pipeline control and the storage array.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface array_if #(
	parameter int unsigned AW = 17,
	parameter int unsigned DW = 36,
	parameter int unsigned LN = 4
);
	logic          wr_en;
	logic          rd_en;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [LN-1:0] lane_en;
	logic [DW-1:0] rdata;

	modport ctrl (output wr_en, output rd_en, output addr, output wdata, output lane_en,
		input rdata);
	modport mem (input wr_en, input rd_en, input addr, input wdata, input lane_en,
		output rdata);
endinterface

// [design/sram_array.sv]
/*
 * Storage array with per-lane write and registered read port.
 * Assumes read and write are never requested in the same cycle.
 */
`timescale 1ns/1ps
module sram_array #(
	parameter int unsigned AW = 17,
	parameter int unsigned DW = 36,
	parameter int unsigned LN = 4
) (
	// clock
	input  wire logic clk_sys,
	// access port
	array_if.mem      port
);
	localparam int unsigned LW = DW / LN;

	logic [DW-1:0] mem_q [2**AW]; // R01
	logic [DW-1:0] rdata_q;

	//--------------------------------------------------------------------------
	// storage
	//--------------------------------------------------------------------------
	// no reset: contents are undefined at power-up, as in any static ram
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < LN; i++) begin
			if (port.wr_en && port.lane_en[i]) begin
				mem_q[port.addr][i*LW +: LW] <= port.wdata[i*LW +: LW]; // R09
			end
		end
		if (port.rd_en) begin
			rdata_q <= mem_q[port.addr];
		end
	end

	assign port.rdata = rdata_q;
endmodule

// [design/sram_core.sv]
/*
 * Pipelined synchronous SRAM core: two-stage address/control pipeline,
 * four-beat burst counter, byte writes and a registered read path.
 * Assumes all inputs except burst_order_select and output_enable_n are synchronous to clk_sys.
 */
`timescale 1ns/1ps
module sram_core
	import sram_pkg::*;
#(
	parameter int unsigned ADDR_W = sram_pkg::ADDR_W_DEF,
	parameter int unsigned DATA_W = sram_pkg::DATA_W_DEF,
	parameter int unsigned LANES  = sram_pkg::LANES_DEF
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	// address and control
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              advance_or_load,
	input  wire logic              read_write,
	input  wire logic              cycle_hold_n,
	input  wire logic [LANES-1:0]  byte_write_n,
	// chip selects
	input  wire logic              chip_select_low_a_n,
	input  wire logic              chip_select_low_b_n,
	input  wire logic              chip_select_high,
	// static and asynchronous controls
	input  wire logic              burst_order_select,
	input  wire logic              output_enable_n,
	// data lines
	input  wire logic [DATA_W-1:0] data_lines_i,
	output logic      [DATA_W-1:0] data_lines_o,
	output logic                   data_lines_oe
);
	import sram_pkg::*;

	// burst address low bits for a given beat
	function automatic logic [1:0] burst_low(input logic [1:0] start,
		input logic [1:0] beat, input logic interleave);
		burst_low = interleave ? (start ^ beat) : 2'(start + beat); // R17
	endfunction

	//--------------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------------
	// burst counter group
	burst_state_e      state_q, state_d;
	logic [ADDR_W-1:0] base_q, base_d;
	logic [BEAT_W-1:0] beat_q, beat_d;
	logic              bwr_q, bwr_d;
	// pipeline group: stage 1 after the control edge, stage 2 one edge later
	logic              v1_q, v1_d, w1_q, w1_d;
	logic [ADDR_W-1:0] a1_q, a1_d;
	logic [LANES-1:0]  bw1_q, bw1_d;
	logic              v2_q, v2_d, w2_q, w2_d;
	logic [ADDR_W-1:0] a2_q, a2_d;
	logic [LANES-1:0]  bw2_q, bw2_d;
	logic              drive_q, drive_d;
	logic              order_s1_q, order_q;

	logic              run;
	logic              selected;
	logic [BEAT_W-1:0] beat_next;
	// operation handed from the burst counter to the pipeline this cycle
	logic              issue;
	logic              issue_wr;
	logic [ADDR_W-1:0] issue_addr;

	array_if #(.AW(ADDR_W), .DW(DATA_W), .LN(LANES)) arr ();

	assign run       = !cycle_hold_n;                                     // R04
	assign selected  = !chip_select_low_a_n && !chip_select_low_b_n
		&& chip_select_high;                                                // R08 R15
	assign beat_next = BEAT_W'(beat_q + BEAT_STEP);

	//--------------------------------------------------------------------------
	// burst counter: next state
	//--------------------------------------------------------------------------
	always_comb begin
		state_d    = state_q;
		base_d     = base_q;
		beat_d     = beat_q;
		bwr_d      = bwr_q;
		issue      = 1'b0;
		issue_wr   = bwr_q;
		// beat address is formed every cycle; only an advance that issues uses it
		issue_addr = {base_q[ADDR_W-1:2],
			burst_low(base_q[1:0], beat_next, order_q)};                    // R11 R17
		if (run) begin
			if (!advance_or_load) begin                                     // R12
				if (selected) begin
					state_d    = BURST_RUN;
					base_d     = address;
					beat_d     = BEAT_ZERO;
					bwr_d      = !read_write;
					issue      = 1'b1;                                      // R02
					issue_wr   = !read_write;
					issue_addr = address;
				end else begin
					state_d = BURST_IDLE;                                   // R14 R05
				end
			end else begin
				// address pins are not looked at on an advance cycle
				case (state_q)                                              // R13
					BURST_RUN: begin
						if (beat_q == BEAT_LAST) begin
							state_d = BURST_IDLE;                           // R10
						end else begin
							beat_d = beat_next;                             // R12
							issue  = 1'b1;
						end
					end
					BURST_IDLE: begin
						state_d = BURST_IDLE;
					end
					default: begin
						state_d = BURST_IDLE;
					end
				endcase
			end
		end
	end

	//--------------------------------------------------------------------------
	// pipeline: next state
	//--------------------------------------------------------------------------
	always_comb begin
		v1_d    = v1_q;
		w1_d    = w1_q;
		a1_d    = a1_q;
		bw1_d   = bw1_q;
		v2_d    = v2_q;
		w2_d    = w2_q;
		a2_d    = a2_q;
		bw2_d   = bw2_q;
		drive_d = drive_q;
		// a held edge freezes both stages, so nothing slips out of step
		if (run) begin
			// second stage advances on every live edge, so pending transfers finish
			v2_d    = v1_q;                                                 // R05
			w2_d    = w1_q;
			a2_d    = a1_q;
			bw2_d   = bw1_q;
			// bus drives only for a read; writes and deselects release it
			drive_d = v2_q && !w2_q;                                        // R06 R03
			v1_d    = issue;
			if (issue) begin
				w1_d  = issue_wr;
				a1_d  = issue_addr;
				bw1_d = byte_write_n;                                       // R09 R16
			end
		end
	end

	//--------------------------------------------------------------------------
	// registers
	//--------------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= BURST_IDLE;
			base_q  <= '0;
			beat_q  <= BEAT_ZERO;
			bwr_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			base_q  <= base_d;
			beat_q  <= beat_d;
			bwr_q   <= bwr_d;
		end
	end

	// pipeline registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			v1_q    <= 1'b0;
			w1_q    <= 1'b0;
			a1_q    <= '0;
			bw1_q   <= '1;
			v2_q    <= 1'b0;
			w2_q    <= 1'b0;
			a2_q    <= '0;
			bw2_q   <= '1;
			drive_q <= 1'b0;
		end else begin
			v1_q    <= v1_d;
			w1_q    <= w1_d;
			a1_q    <= a1_d;
			bw1_q   <= bw1_d;
			v2_q    <= v2_d;
			w2_q    <= w2_d;
			a2_q    <= a2_d;
			bw2_q   <= bw2_d;
			drive_q <= drive_d;
		end
	end

	// static pin, synchronised anyway since it may be strapped from another domain
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			order_s1_q <= 1'b0;
			order_q    <= 1'b0;
		end else begin
			order_s1_q <= burst_order_select;
			order_q    <= order_s1_q;
		end
	end

	//--------------------------------------------------------------------------
	// array and data lines
	//--------------------------------------------------------------------------
	// write data is taken at the edge two cycles after the load or advance edge that issued the beat
	assign arr.wr_en   = run && v2_q && w2_q;                               // R02
	assign arr.rd_en   = run && v2_q && !w2_q;
	assign arr.addr    = a2_q;
	assign arr.wdata   = data_lines_i;
	assign arr.lane_en = ~bw2_q;                                            // R09

	sram_array #(.AW(ADDR_W), .DW(DATA_W), .LN(LANES)) u_array (
		.clk_sys (clk_sys),
		.port    (arr.mem)
	);

	assign data_lines_o  = arr.rdata;
	// output enable bypasses the clock entirely
	assign data_lines_oe = drive_q && !output_enable_n;                      // R07
endmodule

// [test/sram_core_asserts.sv]
/*
 * Port timing checker for sram_core.
 * Assumes it is bound to every sram_core instance.
 */
`timescale 1ns/1ps
module sram_core_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// control
	input wire logic advance_or_load,
	input wire logic read_write,
	input wire logic cycle_hold_n,
	input wire logic chip_select_low_a_n,
	input wire logic chip_select_low_b_n,
	input wire logic chip_select_high,
	input wire logic output_enable_n,
	// data lines
	input wire logic data_lines_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	wire sel = !chip_select_low_a_n && !chip_select_low_b_n && chip_select_high;
	// ----
	// sequences
	// ----
	sequence adv_s; !cycle_hold_n && advance_or_load; endsequence
	sequence rd_s; !cycle_hold_n && !advance_or_load && sel && read_write; endsequence
	sequence wr_s; !cycle_hold_n && !advance_or_load && sel && !read_write; endsequence
	sequence off_s; !cycle_hold_n && !advance_or_load && !sel; endsequence
	// two live edges, then look with the output gate open
	sequence look_s; (!cycle_hold_n) [*2] ##1 !output_enable_n; endsequence
	oe_async_a: assert property (output_enable_n |-> !data_lines_oe)
		else $error("driving while output disabled");
	hold_freeze_a: assert property (cycle_hold_n ##1 $stable(output_enable_n)
		|-> $stable(data_lines_oe)) else $error("output moved on held edge");
	read_drive_a: assert property (rd_s ##1 look_s |-> data_lines_oe)
		else $error("read not driven two edges on");
	write_release_a: assert property (wr_s ##1 look_s |-> !data_lines_oe)
		else $error("driving in write data cycle");
	off_release_a: assert property (off_s ##1 look_s |-> !data_lines_oe)
		else $error("driving after deselect");
	burst_beats_a: assert property (rd_s ##1 adv_s [*3] ##1 look_s |-> data_lines_oe)
		else $error("fourth beat not driven");
	burst_end_a: assert property (rd_s ##1 adv_s [*4] ##1 look_s |-> !data_lines_oe)
		else $error("burst ran past four beats");
	idle_adv_a: assert property (off_s ##1 adv_s ##1 look_s |-> !data_lines_oe)
		else $error("advance revived ended burst");
endmodule

bind sram_core sram_core_asserts u_sram_core_asserts (.clk_sys, .arst_n, .advance_or_load,
	.read_write, .cycle_hold_n, .chip_select_low_a_n, .chip_select_low_b_n,
	.chip_select_high, .output_enable_n, .data_lines_oe);

// [test/sram_ctrl_model.sv]
/*
 * Controller side of the data lines: drives write data on write data edges.
 * Assumes the bench tells it when the next edge moves write data.
 */
`timescale 1ns/1ps
module sram_ctrl_model (
	// clock
	input  wire logic        clk_sys,
	// write data request
	input  wire logic        drv,
	input  wire logic [35:0] wdata,
	// data lines
	output logic      [35:0] data_lines_i
);
	// ----
	// data driver
	// ----
	logic [35:0] last_q = 36'h0_0000_0000;
	always_ff @(posedge clk_sys) if (drv) last_q <= wdata;
	// released lines show the inverse so stale data never passes for a write
	assign data_lines_i = drv ? wdata : ~last_q;
endmodule

// [test/pipelined_zero_turnaround_sram_tb.sv]
/*
 * Self-checking bench for sram_core against a cycle model.
 * Assumes sram_core default widths (36-bit words, four 9-bit lanes).
 */
`timescale 1ns/1ps
module pipelined_zero_turnaround_sram_tb;
	logic        clk_sys = 1'h0, arst_n = 1'h0, advance_or_load = 1'h0, read_write = 1'h0;
	logic        cycle_hold_n = 1'h0, drv = 1'h0, brw, data_lines_oe;
	logic        chip_select_low_a_n = 1'h1, chip_select_low_b_n = 1'h1, chip_select_high = 1'h0;
	logic        burst_order_select = 1'h0, output_enable_n = 1'h0;
	logic [16:0] address = 17'h0_0000;
	logic [3:0]  byte_write_n = 4'hf;
	logic [5:0]  base;
	logic [11:0] st [2] = '{default: 12'h000};
	logic [35:0] wdata = 36'h0_0000_0000, data_lines_i, data_lines_o, exp_dat;
	logic [35:0] mem [64];
	logic [31:0] r = 32'h2101_b694;
	int          bad_count, num_checks, run, beat, exp_drv, fill;
	sram_core u_sram_core (.clk_sys, .arst_n, .address, .advance_or_load, .read_write,
		.cycle_hold_n, .byte_write_n, .chip_select_low_a_n, .chip_select_low_b_n,
		.chip_select_high, .burst_order_select, .output_enable_n, .data_lines_i,
		.data_lines_o, .data_lines_oe);
	sram_ctrl_model u_sram_ctrl_model (.clk_sys, .drv, .wdata, .data_lines_i);
	initial forever #4 clk_sys = ~clk_sys;
	// ----
	// model: st = {valid, write, lane selects, address}
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
	endfunction
	task automatic edge_model();
		logic [1:0] lo;
		if (cycle_hold_n) return;
		exp_drv = 0;
		for (int i = 0; i < 4; i++)
			if (st[1][11:10] == 2'h3 && !st[1][6+i])
				mem[st[1][5:0]][i*9+:9] = data_lines_i[i*9+:9];
		if (st[1][11:10] == 2'h2) begin
			exp_drv = 1;
			exp_dat = mem[st[1][5:0]];
		end
		st[1] = st[0];
		if (!advance_or_load) begin
			run = !chip_select_low_a_n && !chip_select_low_b_n && chip_select_high;
			beat = 0;
			base = address[5:0];
			brw = read_write;
			st[0] = {run[0], !read_write, byte_write_n, address[5:0]};
		end else if (run != 0 && beat < 3) begin
			beat++;
			lo = burst_order_select ? base[1:0] ^ beat[1:0] : base[1:0] + beat[1:0];
			st[0] = {1'b1, !brw, byte_write_n, base[5:2], lo};
		end else begin
			run = 0;
			st[0] = 12'h000;
		end
	endtask
	task automatic cyc();
		logic [2:0] s;
		@(posedge clk_sys);
		edge_model();
		r = lfsr(r);
		s = (r[3:0] != 4'h1 || fill != 0) ? 3'h7 : (r[30:28] == 3'h7 ? 3'h6 : r[30:28]);
		cycle_hold_n <= (r[3:0] == 4'h0) && fill == 0;
		advance_or_load <= (r[3:0] > 4'h5) && fill == 0;
		read_write <= r[13] && fill == 0;
		address <= {11'h000, (fill != 0) ? 6'(fill - 1) : r[19:14]};
		byte_write_n <= (fill != 0) ? 4'h0 : r[24:21];
		{chip_select_high, chip_select_low_b_n, chip_select_low_a_n} <= s ^ 3'h3;
		output_enable_n <= (r[9:4] == 6'h00);
		drv <= (st[1][11:10] == 2'h3);
		wdata <= {r[7:4], lfsr(r)};
		if (fill > 0) fill--;
		#2;
		num_checks++;
		if (data_lines_oe !== (exp_drv != 0 && !output_enable_n)) begin
			$display("FAIL data_lines_oe exp %b got %b", exp_drv != 0 && !output_enable_n,
				data_lines_oe);
			bad_count++;
		end
		if (exp_drv != 0 && data_lines_o !== exp_dat) begin
			$display("FAIL data_lines_o exp %h got %h", exp_dat, data_lines_o);
			bad_count++;
		end
	endtask
	task automatic complete_run();
		if (bad_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----
	// sequence: one random pass per burst order, each behind a reset;
	// the first pass opens with whole-word writes so no read compares unknowns
	// ----
	initial begin
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys);
			edge_model();
			arst_n <= 1'h0;
			advance_or_load <= 1'h0;
			chip_select_high <= 1'h0;
			drv <= 1'h0;
			burst_order_select <= p[0];
			run = 0;
			exp_drv = 0;
			fill = (p == 0) ? 64 : 0;
			st = '{default: 12'h000};
			repeat (5) @(posedge clk_sys);
			arst_n <= 1'h1;
			repeat (400) cyc();
		end
		complete_run();
	end
	initial begin
		#10000;
		bad_count++;
		complete_run();
	end
endmodule
